/* iobs_defs.svh */
// constants for the i/o bus station interrupt control block
// assumes the including file uses these macros in a single clock domain
// Summary of operation
// - read/write moves one 8-bit character
// - device ready raises interrupt request
// - channel request takes next memory cycle
// - seven-bit device address, 128 devices
// - input address even, output address odd
// - bit 7 odd parity, respond only correct
// - address taken from register at execution
// - station passes signals only to own devices
// - nearest station wins, others held
// - nearest device in station wins, rest stacked
// - mask load copies accumulator, 1 inhibits
// - accumulator bit n controls station n
// - cpu inhibit bit set on interrupt taken
// - enable-jump clears inhibit, disable-jump sets it
// - enabled station device requests when ready
// - inhibited requests held pending
// - interrupt saves pc at 0,1, resumes at 2
// - acknowledge returns seven-bit device address
// - 8-bit status register readable per device
// - terminal status codes 0000, 1011, 1100
`ifndef IOBS_DEFS_SVH
`define IOBS_DEFS_SVH
`define IOBS_MASK_RESET 8'hff
`define IOBS_INHIBIT_RESET 1'b1
`define IOBS_PC_SAVE_HI 16'h0000
`define IOBS_PC_SAVE_LO 16'h0001
`define IOBS_VECTOR 16'h0002
`define IOBS_RDY_IDLE 4'h0
`define IOBS_RDY_RX 4'hb
`define IOBS_RDY_TX 4'hc
`define IOBS_RDY_LSB 4
`define IOBS_ERR_BIT 0
`define IOBS_PAR_BIT 7
`endif

/* iobs_pkg.sv */
// types for the i/o bus station interrupt control block
// assumes iobs_defs.svh is visible to users of the constants
package iobs_pkg;
    typedef enum logic [3:0] {
        IOBS_OP_NONE,
        IOBS_OP_READ,
        IOBS_OP_WRITE,
        IOBS_OP_CONTROL,
        IOBS_OP_STATUS,
        IOBS_OP_SKIP_TRUE,
        IOBS_OP_SKIP_FALSE,
        IOBS_OP_MASK_LOAD,
        IOBS_OP_ACK,
        IOBS_OP_ENABLE,
        IOBS_OP_DISABLE
    } iobs_op_type;
    typedef struct packed {
        iobs_op_type op;
        logic [7:0] dev_addr;
        logic [7:0] acc;
        logic [7:0] operand;
    } iobs_cmd_type;
    typedef struct packed {
        logic valid;
        logic [7:0] acc;
        logic skip;
    } iobs_rsp_type;
endpackage

/* iobs_station_ctrl.sv */
// i/o bus control unit: device select, station masks, priority chain, interrupt entry
// assumes one cpu command per cycle at most, synchronous inputs, one clock domain
`timescale 1ns/10ps
`include "iobs_defs.svh"

module iobs_station_ctrl
    import iobs_pkg::*;
#(
    parameter int NUM_STATIONS = 8,
    parameter int DEVS_PER_STATION = 16,
    parameter logic [127:0] PARITY_DEVS = 128'h0
) (
    input wire logic mclk_in, // 125 mhz clock
    input wire logic srst_in, // synchronous reset, active high
    input wire iobs_cmd_type cmd_in, // cpu i/o instruction
    input wire logic [127:0] dev_ready_in, // per-device ready pulse
    input wire logic [127:0] dev_chan_req_in, // per-device channel demand
    input wire logic [1023:0] dev_status_in, // 8-bit status per device
    input wire logic [1023:0] dev_rx_char_in, // received char per device
    input wire logic mem_cycle_in, // a memory cycle boundary
    output iobs_rsp_type rsp_out, // answer to cpu
    output logic [127:0] dev_sel_out, // one-hot device select
    output logic [7:0] dev_data_out, // char or control to device
    output logic dev_write_out, // write strobe
    output logic dev_control_out, // control strobe
    output logic [127:0] chan_grant_out, // channel cycle grant
    output logic int_req_out, // interrupt to cpu
    output logic [15:0] pc_save_addr_out, // page 0 save address
    output logic [15:0] vector_out, // page 0 entry address
    output logic [7:0] station_mask_out, // mask bits
    output logic cpu_inhibit_out // cpu interrupt inhibit
);
    localparam int NDEV = NUM_STATIONS * DEVS_PER_STATION;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    logic [7:0] mask_q, mask_d;
    logic inhibit_q, inhibit_d;
    logic [127:0] pend_q, pend_d;
    logic [6:0] owner_q;
    logic owner_v_q;
    wire [6:0] dev_idx = cmd_in.dev_addr[6:0];
    wire par_ok = ^cmd_in.dev_addr;
    wire par_need = PARITY_DEVS[dev_idx];
    wire addr_ok = (!par_need || par_ok) && (int'(dev_idx) < NDEV);
    wire io_op = cmd_in.op inside {IOBS_OP_READ, IOBS_OP_WRITE, IOBS_OP_CONTROL,
        IOBS_OP_STATUS, IOBS_OP_SKIP_TRUE, IOBS_OP_SKIP_FALSE};
    wire [7:0] sel_status = dev_status_in[dev_idx*8 +: 8];
    wire [7:0] sel_rx = dev_rx_char_in[dev_idx*8 +: 8];
    wire skip_t = ((sel_status & cmd_in.operand) == cmd_in.operand);
    wire skip_f = ((sel_status & ~cmd_in.operand) == 8'h00);
    wire ack = cmd_in.op == IOBS_OP_ACK;

    ////////////////////////////////////////////////////////////////////////
    // priority chain: lowest index is station 0 nearest device
    logic [127:0] eligible;
    logic [6:0] win_idx;
    logic win_v;
    logic [127:0] chan_win;
    always_comb begin
        win_idx = 7'h00;
        win_v = 1'b0;
        chan_win = '0;
        for (int i = 0; i < 128; i++) begin
            eligible[i] = pend_q[i] && (i < NDEV) && !mask_q[i / DEVS_PER_STATION];
        end
        for (int i = 127; i >= 0; i--) begin
            if (eligible[i]) begin
                win_idx = 7'(i);
                win_v = 1'b1;
            end
        end
        for (int i = 127; i >= 0; i--) begin
            if (dev_chan_req_in[i] && i < NDEV) begin
                chan_win = '0;
                chan_win[i] = 1'b1;
            end
        end
    end
    wire take = win_v && !inhibit_q && !owner_v_q;

    ////////////////////////////////////////////////////////////////////////
    // state next values
    always_comb begin
        mask_d = mask_q;
        inhibit_d = inhibit_q;
        pend_d = pend_q | dev_ready_in;
        if (cmd_in.op == IOBS_OP_MASK_LOAD) begin
            mask_d = cmd_in.acc;
        end
        if (cmd_in.op == IOBS_OP_ENABLE) begin
            inhibit_d = 1'b0;
        end
        if (cmd_in.op == IOBS_OP_DISABLE || take) begin
            inhibit_d = 1'b1;
        end
        if (ack && owner_v_q && !dev_ready_in[owner_q]) begin
            pend_d[owner_q] = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            mask_q <= `IOBS_MASK_RESET;
            inhibit_q <= `IOBS_INHIBIT_RESET;
            pend_q <= '0;
            owner_q <= 7'h00;
            owner_v_q <= 1'b0;
        end else begin
            mask_q <= mask_d;
            inhibit_q <= inhibit_d;
            pend_q <= pend_d;
            if (take) begin
                owner_q <= win_idx;
                owner_v_q <= 1'b1;
            end else if (ack) begin
                owner_v_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rsp_out <= '0;
            dev_sel_out <= '0;
            dev_data_out <= 8'h00;
            dev_write_out <= 1'b0;
            dev_control_out <= 1'b0;
            chan_grant_out <= '0;
            int_req_out <= 1'b0;
            pc_save_addr_out <= `IOBS_PC_SAVE_HI;
            vector_out <= `IOBS_VECTOR;
        end else begin
            // fixed page 0 addresses, still held in flops so every output is registered
            pc_save_addr_out <= `IOBS_PC_SAVE_HI;
            vector_out <= `IOBS_VECTOR;
            rsp_out.valid <= cmd_in.op != IOBS_OP_NONE;
            rsp_out.skip <= (cmd_in.op == IOBS_OP_SKIP_TRUE && addr_ok && skip_t) ||
                (cmd_in.op == IOBS_OP_SKIP_FALSE && addr_ok && skip_f);
            rsp_out.acc <= cmd_in.acc;
            if (cmd_in.op == IOBS_OP_READ && addr_ok) begin
                rsp_out.acc <= sel_rx;
            end else if (cmd_in.op == IOBS_OP_STATUS && addr_ok) begin
                rsp_out.acc <= sel_status;
            end else if (ack) begin
                rsp_out.acc <= {1'b0, owner_q};
            end
            dev_sel_out <= '0;
            if (io_op && addr_ok) begin
                // an odd output address owns its own line, one above its input address
                dev_sel_out[dev_idx] <= 1'b1;
            end
            dev_data_out <= cmd_in.acc;
            dev_write_out <= cmd_in.op == IOBS_OP_WRITE && addr_ok;
            dev_control_out <= cmd_in.op == IOBS_OP_CONTROL && addr_ok;
            chan_grant_out <= mem_cycle_in ? chan_win : '0;
            int_req_out <= take;
        end
    end
    assign station_mask_out = mask_q;
    assign cpu_inhibit_out = inhibit_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    take_sets_inh_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        take |=> cpu_inhibit_out) else $error("inhibit not set on interrupt");
    int_pulse_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        int_req_out |-> $past(win_v) && !$past(inhibit_q))
        else $error("interrupt while inhibited");
    mask_load_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        cmd_in.op == IOBS_OP_MASK_LOAD |=> mask_q == $past(cmd_in.acc))
        else $error("mask not loaded");
    enable_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        cmd_in.op == IOBS_OP_ENABLE && !take |=> !cpu_inhibit_out)
        else $error("enable failed");
    one_grant_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        $onehot0(chan_grant_out)) else $error("multiple grants");
    sel_onehot_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        $onehot0(dev_sel_out)) else $error("multiple selects");
    ack_addr_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        ack |=> rsp_out.acc == {1'b0, $past(owner_q)}) else $error("bad ack");
    masked_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        take |-> !mask_q[int'(win_idx) / DEVS_PER_STATION])
        else $error("masked station won");

    ////////////////////////////////////////////////////////////////////////
    // response and select checks

    rsp_valid_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        cmd_in.op != IOBS_OP_NONE |=> rsp_out.valid)
        else $error("no response to command");

    rsp_idle_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        cmd_in.op == IOBS_OP_NONE |=> !rsp_out.valid)
        else $error("response without command");

    read_data_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        cmd_in.op == IOBS_OP_READ && addr_ok |=> rsp_out.acc == $past(sel_rx))
        else $error("read char wrong");

    status_data_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        cmd_in.op == IOBS_OP_STATUS && addr_ok |=> rsp_out.acc == $past(sel_status))
        else $error("status byte wrong");

    refuse_sel_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        !addr_ok |=> dev_sel_out == '0)
        else $error("refused address selected");

    sel_target_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        io_op && addr_ok |=> dev_sel_out[$past(dev_idx)])
        else $error("addressed device not selected");

    write_strobe_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        cmd_in.op == IOBS_OP_WRITE && addr_ok |=>
        dev_write_out && dev_data_out == $past(cmd_in.acc))
        else $error("write not passed on");

    ctrl_strobe_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        cmd_in.op == IOBS_OP_CONTROL && addr_ok |=> dev_control_out)
        else $error("control not passed on");

    par_refuse_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        par_need && !par_ok |=> !dev_write_out && !dev_control_out && !rsp_out.skip)
        else $error("bad parity accepted");

    ////////////////////////////////////////////////////////////////////////
    // channel checks

    grant_cycle_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        !mem_cycle_in |=> chan_grant_out == '0)
        else $error("grant outside memory cycle");

    grant_given_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        mem_cycle_in && chan_win != '0 |=> chan_grant_out != '0)
        else $error("channel demand not granted");

    ////////////////////////////////////////////////////////////////////////
    // mask, inhibit, pending and interrupt pulse checks

    disable_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        cmd_in.op == IOBS_OP_DISABLE |=> cpu_inhibit_out)
        else $error("disable failed");

    mask_hold_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        cmd_in.op != IOBS_OP_MASK_LOAD |=> mask_q == $past(mask_q))
        else $error("mask changed without load");

    ready_sets_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        dev_ready_in != '0 |=> (pend_q & $past(dev_ready_in)) == $past(dev_ready_in))
        else $error("ready not made pending");

    pend_hold_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        !ack |=> (pend_q & $past(pend_q)) == $past(pend_q))
        else $error("pending request lost");

    int_once_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        int_req_out |=> !int_req_out)
        else $error("interrupt pulse too long");

    ////////////////////////////////////////////////////////////////////////
    // priority, ownership and page 0 address checks

    win_prio_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        take |-> (eligible & ((128'h1 << win_idx) - 128'h1)) == '0)
        else $error("lower priority won");

    take_owner_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        take |=> owner_v_q && owner_q == $past(win_idx))
        else $error("owner not recorded");

    owner_hold_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        owner_v_q && !ack |=> owner_v_q && owner_q == $past(owner_q))
        else $error("owner lost before acknowledge");

    ack_clear_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        ack && owner_v_q && !dev_ready_in[owner_q] |=> !pend_q[$past(owner_q)])
        else $error("acknowledge left request pending");

    page0_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        vector_out == `IOBS_VECTOR && pc_save_addr_out == `IOBS_PC_SAVE_HI)
        else $error("page 0 addresses wrong");
endmodule

/* iobs_dev_model.sv */
// device controller model: a status byte and a buffered character for every device
// assumes device index i owns byte lane [8i+:8] of both buses
`timescale 1ns/10ps
module iobs_dev_model (
    output logic [1023:0] status_out, // status byte per device
    output logic [1023:0] rx_char_out // received character per device
);
    ////////////////////////////////////////
    // the pattern varies per device, so a select error shows up as a wrong byte
    always_comb begin
        for (int i = 0; i < 128; i++) begin
            rx_char_out[8*i+:8] = i[7:0] ^ 8'h5a;
            status_out[8*i+:8] = {(i % 3 == 0) ? 4'h0 : (i % 3 == 1) ? 4'hb : 4'hc,
                3'h0, i % 5 == 0};
        end
    end
endmodule

/* tb_io_bus_station_interrupt_control.sv */
// self-checking bench for the station interrupt control block
// assumes the device model supplies status and characters; the bench drives the rest
`timescale 1ns/10ps
module tb_io_bus_station_interrupt_control;
    import iobs_pkg::*;
    typedef struct {logic [7:0] acc; logic skip; bit ca; bit cs;} iobs_exp_type;
    logic mclk_in = 1'b0;
    logic srst_in = 1'b1;
    iobs_cmd_type cmd_in = '0;
    logic [127:0] ready = '0;
    logic [127:0] chan = '0;
    logic mem_cycle = 1'b0;
    logic [1023:0] status, rx;
    iobs_rsp_type rsp;
    logic [127:0] sel, grant;
    logic int_req, inhibit, wr, ctl;
    logic [7:0] data;
    logic [7:0] mask;
    logic [15:0] vec, pcs;
    logic [15:0] rng = 16'h8330;
    int err_count = 0;
    int checked = 0;
    iobs_exp_type q[$];
    iobs_exp_type e;
    iobs_station_ctrl #(.PARITY_DEVS(128'h400)) i_dut (.mclk_in(mclk_in), .srst_in(srst_in),
        .cmd_in(cmd_in), .dev_ready_in(ready), .dev_chan_req_in(chan), .dev_status_in(status),
        .dev_rx_char_in(rx), .mem_cycle_in(mem_cycle), .rsp_out(rsp), .dev_sel_out(sel),
        .dev_data_out(data), .dev_write_out(wr), .dev_control_out(ctl), .chan_grant_out(grant),
        .int_req_out(int_req), .pc_save_addr_out(pcs), .vector_out(vec),
        .station_mask_out(mask), .cpu_inhibit_out(inhibit));
    iobs_dev_model i_model (.status_out(status), .rx_char_out(rx));
    always #4 mclk_in = ~mclk_in;
    ////////////////////////////////////////
    function automatic logic [15:0] nxt(logic [15:0] x);
        x ^= x << 7;
        x ^= x >> 9;
        x ^= x << 8;
        return x;
    endfunction
    task automatic results;
        if (err_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(string n, logic [127:0] x, logic [127:0] s);
        checked++;
        if (x !== s) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic op(iobs_op_type o, logic [7:0] a, logic [7:0] acc, logic [7:0] m,
                      logic [7:0] ea, logic es, bit ca, bit cs);
        @(negedge mclk_in);
        cmd_in <= '{o, a, acc, m};
        q.push_back('{ea, es, ca, cs});
    endtask
    task automatic idle(int n);
        @(negedge mclk_in);
        cmd_in.op <= IOBS_OP_NONE;
        repeat (n) @(negedge mclk_in);
    endtask
    task automatic take_int(logic [6:0] owner);
        int n = 0;
        op(IOBS_OP_ENABLE, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 0, 0);
        idle(0);
        while (int_req !== 1'b1 && n < 20) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        chk("int taken", 1, int_req);
        chk("inhibit after int", 1, inhibit);
        idle(2);
        op(IOBS_OP_ACK, 8'h00, 8'h00, 8'h00, {1'b0, owner}, 1'b0, 1, 0);
        idle(2);
    endtask
    // one result per command, taken in issue order
    always @(posedge mclk_in) begin
        #1;
        if (rsp.valid === 1'b1) begin
            if (q.size() == 0) chk("extra response", 1, 0);
            else begin
                e = q.pop_front();
                if (e.ca) chk("rsp acc", e.acc, rsp.acc);
                if (e.cs) chk("rsp skip", e.skip, rsp.skip);
            end
        end
    end
    initial begin
        #100000;
        err_count++;
        results();
    end
    ////////////////////////////////////////
    initial begin
        logic [6:0] a;
        logic [7:0] s;
        repeat (8) @(negedge mclk_in);
        srst_in <= 1'b0;
        chk("mask reset", 8'hff, mask);
        chk("inhibit reset", 1, inhibit);
        chk("vector", 16'h0002, vec);
        chk("save addr", 16'h0000, pcs);
        for (int k = 0; k < 8; k++) begin
            rng = nxt(rng);
            a = (rng[6:0] == 7'd10) ? 7'd11 : rng[6:0];
            op(IOBS_OP_READ, {1'b0, a}, rng[15:8], 8'h00, a ^ 8'h5a, 0, 1, 0);
        end
        op(IOBS_OP_READ, 8'h05, 8'h00, 8'h00, 8'h5f, 0, 1, 0);
        idle(0);
        chk("select", 128'h1 << 5, sel);
        op(IOBS_OP_READ, 8'h8a, 8'h33, 8'h00, 8'h50, 0, 1, 0);
        op(IOBS_OP_READ, 8'h0a, 8'h33, 8'h00, 8'h33, 0, 1, 1);
        op(IOBS_OP_WRITE, 8'h21, 8'h7e, 8'h00, 8'h7e, 0, 1, 0);
        idle(0);
        chk("write select", 128'h1 << 33, sel);
        chk("write strobe", 1, wr);
        chk("write data", 8'h7e, data);
        for (int d = 3; d < 6; d++) begin
            s = {(d % 3 == 0) ? 4'h0 : (d % 3 == 1) ? 4'hb : 4'hc, 3'h0, d % 5 == 0};
            op(IOBS_OP_STATUS, 8'(d), 8'h00, 8'h00, s, 0, 1, 0);
            op(IOBS_OP_SKIP_TRUE, 8'(d), 8'h00, 8'hb0, 0, (s & 8'hb0) == 8'hb0, 0, 1);
            op(IOBS_OP_SKIP_FALSE, 8'(d), 8'h00, 8'hc0, 0, (s & 8'h3f) == 0, 0, 1);
        end
        op(IOBS_OP_MASK_LOAD, 8'h00, 8'h02, 8'h00, 0, 0, 0, 0);
        op(IOBS_OP_ENABLE, 8'h00, 8'h00, 8'h00, 0, 0, 0, 0);
        idle(0);
        chk("mask load", 8'h02, mask);
        chk("enable clears", 0, inhibit);
        op(IOBS_OP_DISABLE, 8'h00, 8'h00, 8'h00, 0, 0, 0, 0);
        idle(0);
        chk("disable sets", 1, inhibit);
        ready <= (128'h1 << 20) | (128'h1 << 35) | (128'h1 << 40);
        @(negedge mclk_in);
        ready <= '0;
        take_int(7'd35);
        take_int(7'd40);
        op(IOBS_OP_MASK_LOAD, 8'h00, 8'h00, 8'h00, 0, 0, 0, 0);
        idle(0);
        take_int(7'd20);
        op(IOBS_OP_CONTROL, 8'h07, 8'h83, 8'h00, 8'h83, 0, 1, 0);
        op(IOBS_OP_CONTROL, 8'h03, 8'h83, 8'h00, 8'h83, 0, 1, 0);
        idle(0);
        chk("control strobe", 1, ctl);
        chk("control select", 128'h1 << 3, sel);
        chan <= (128'h1 << 7) | (128'h1 << 3);
        @(negedge mclk_in);
        chk("no grant off cycle", 0, grant);
        mem_cycle <= 1'b1;
        @(negedge mclk_in);
        chk("grant", 128'h1 << 3, grant);
        chan <= '0;
        mem_cycle <= 1'b0;
        idle(4);
        chk("queue empty", 0, q.size());
        results();
    end
endmodule
